/* core/cms_pkg.sv */
// package for the measurement sequencer: timing, config and event types
// assumes clk_sys runs at CMS_CLK_MHZ; every time below is in microseconds
package cms_pkg;

  // ==========================================================
  // time base
  // ==========================================================
  localparam int unsigned CMS_CLK_MHZ     = 25;
  // nominal analog oscillator; timing here is rescaled onto clk_sys
  localparam int unsigned CMS_OSC_KHZ     = 1850;

  // ==========================================================
  // phase times (us) and their lengths in clk_sys cycles
  // ==========================================================
  localparam int unsigned CMS_WIN_SHORT_US = 3000;
  localparam int unsigned CMS_WIN_LONG_US  = 10000;
  localparam int unsigned CMS_WAKE_US      = 100;
  localparam int unsigned CMS_TCALC_US     = 250;
  localparam int unsigned CMS_CCALC_US     = 300;
  localparam int unsigned CMS_CONV0_US     = 300;
  localparam int unsigned CMS_CONV1_US     = 1150;
  localparam int unsigned CMS_CONV2_US     = 4500;
  localparam int unsigned CMS_CONV3_US     = 18000;
  localparam int unsigned CMS_PD1_US       = 5000;
  localparam int unsigned CMS_PD2_US       = 25000;
  localparam int unsigned CMS_PD3_US       = 125000;

  localparam int unsigned CMS_WIN_SHORT_CYC = CMS_WIN_SHORT_US * CMS_CLK_MHZ;
  localparam int unsigned CMS_WIN_LONG_CYC  = CMS_WIN_LONG_US * CMS_CLK_MHZ;
  localparam int unsigned CMS_WAKE_CYC      = CMS_WAKE_US * CMS_CLK_MHZ;
  localparam int unsigned CMS_TCALC_CYC     = CMS_TCALC_US * CMS_CLK_MHZ;
  localparam int unsigned CMS_CCALC_CYC     = CMS_CCALC_US * CMS_CLK_MHZ;
  localparam int unsigned CMS_CONV0_CYC     = CMS_CONV0_US * CMS_CLK_MHZ;
  localparam int unsigned CMS_CONV1_CYC     = CMS_CONV1_US * CMS_CLK_MHZ;
  localparam int unsigned CMS_CONV2_CYC     = CMS_CONV2_US * CMS_CLK_MHZ;
  localparam int unsigned CMS_CONV3_CYC     = CMS_CONV3_US * CMS_CLK_MHZ;
  localparam int unsigned CMS_PD1_CYC       = CMS_PD1_US * CMS_CLK_MHZ;
  localparam int unsigned CMS_PD2_CYC       = CMS_PD2_US * CMS_CLK_MHZ;
  localparam int unsigned CMS_PD3_CYC       = CMS_PD3_US * CMS_CLK_MHZ;

  // ==========================================================
  // counts, widths and reset values
  // ==========================================================
  localparam int unsigned CMS_CNT_W        = 22;
  localparam logic [2:0]  CMS_TEMP_LAST    = 3'h5;
  localparam logic [2:0]  CMS_CAP_CNT_RST  = 3'h0;
  localparam logic [3:0]  CMS_RES_BASE     = 4'h8;
  localparam logic        CMS_I2C_RST      = 1'h1;

  // ==========================================================
  // types
  // ==========================================================
  typedef enum logic [3:0] {
    ST_BOOT, ST_WINDOW, ST_CMD, ST_WAKE, ST_TCONV, ST_TCALC,
    ST_CCONV, ST_CCALC, ST_PDOWN, ST_SLEEP
  } cms_state_t;

  typedef struct packed {
    logic       sleep_mode;
    logic [1:0] rate_code;
    logic [1:0] res_code;
    logic       short_start;
  } cms_cfg_t;

  typedef struct packed {
    logic enter_calibration_command;
    logic resume_normal_command;
    logic measure_request_cmd;
  } cms_cmd_t;

  typedef struct packed {
    logic conv_start;
    logic conv_is_temp;
    logic dsp_start;
    logic result_write;
  } cms_evt_t;

endpackage

/* core/cms_timer.sv */
// down-counter that times one sequencer phase
// assumes load_i pulses in the last cycle before each phase
`timescale 1ns/10ps
module cms_timer #(
  parameter int unsigned CNT_W = cms_pkg::CMS_CNT_W
) (
  // clock and reset
  input  wire logic             clk_sys_i,
  input  wire logic             reset_i,
  // phase control
  input  wire logic             load_i,
  input  wire logic [CNT_W-1:0] len_i,
  output logic                  expired_o
);
  import cms_pkg::*;

  logic [CNT_W-1:0] count;
  wire  [CNT_W-1:0] count_dec  = count - 1'b1;
  wire  [CNT_W-1:0] next_count = load_i ? len_i - 1'b1
                                 : (count != '0) ? count_dec : count;

  always_ff @(posedge clk_sys_i)
  begin
    if (reset_i)
      count <= '0;
    else
      count <= next_count;
  end

  // a phase of len cycles ends in its last cycle
  assign expired_o = (count == '0);

endmodule

/* core/cms_sequencer.sv */
// measurement sequencer of the capacitive conditioner digital core
// assumes commands arrive as one-cycle pulses from serial logic on clk_sys
// and config bits are stable levels from the nonvolatile setup logic
`timescale 1ns/10ps

// Behaviour
// - all phase timing derives from one time base, the system clock
// - after reset release, clock generator starts before power-up sequence
// - device answers as I2C slave at least during the command window
// - command window lasts 3 ms with short-start set, else 10 ms
// - enter-calibration command within window enters Command Mode and stays
// - window expiry or resume-normal command starts one full measurement cycle
// - first result written when capacitance DSP step of first cycle ends
// - cycle order: wakeup, temp conv, temp DSP, cap conv, cap DSP
// - resolution code sets conversion length 0.30, 1.15, 4.50, 18.0 ms
// - every conversion is followed by its DSP calculation
// - one config bit selects update operation or sleep operation
// - rate code sets power-down interval 0, 5, 25 or 125 ms
// - update mode writes result at cycle end, powers down, then wakes
// - fastest rate code runs cycles back to back without power-down
// - update mode converts temperature once every six capacitance cycles
// - cycles without temperature skip both temp conversion and temp DSP
// - sleep mode measurement request runs one cycle with temp and cap
module cms_sequencer #(
  parameter int unsigned WIN_SHORT_CYC = cms_pkg::CMS_WIN_SHORT_CYC,
  parameter int unsigned WIN_LONG_CYC  = cms_pkg::CMS_WIN_LONG_CYC,
  parameter int unsigned WAKE_CYC      = cms_pkg::CMS_WAKE_CYC,
  parameter int unsigned TCALC_CYC     = cms_pkg::CMS_TCALC_CYC,
  parameter int unsigned CCALC_CYC     = cms_pkg::CMS_CCALC_CYC,
  parameter int unsigned CONV_CYC [4]  = '{cms_pkg::CMS_CONV0_CYC,
                                           cms_pkg::CMS_CONV1_CYC,
                                           cms_pkg::CMS_CONV2_CYC,
                                           cms_pkg::CMS_CONV3_CYC},
  parameter int unsigned PD_CYC [4]    = '{1,
                                           cms_pkg::CMS_PD1_CYC,
                                           cms_pkg::CMS_PD2_CYC,
                                           cms_pkg::CMS_PD3_CYC}
) (
  // clock and reset
  input  wire logic               clk_sys_i,
  input  wire logic               reset_i,
  // configuration and host commands
  input  wire cms_pkg::cms_cfg_t  cfg_i,
  input  wire cms_pkg::cms_cmd_t  cmd_i,
  // sequencing events to front end, DSP and output register
  output cms_pkg::cms_evt_t       evt_o,
  output logic [3:0]              conv_bits_o,
  // status
  output cms_pkg::cms_state_t     phase_o,
  output logic                    window_open_o,
  output logic                    cmd_mode_o,
  output logic                    powered_down_o,
  output logic                    i2c_forced_o
);
  import cms_pkg::*;

  localparam int unsigned CNT_W = CMS_CNT_W;

  // ==========================================================
  // phase lengths
  // ==========================================================
  // single time base
  function automatic logic [CNT_W-1:0] phase_len(cms_state_t s,
                                                 cms_cfg_t   c);
    int unsigned n;
    n = 1;
    case (s)
      ST_WINDOW: n = c.short_start ? WIN_SHORT_CYC : WIN_LONG_CYC;
      ST_WAKE:   n = WAKE_CYC;
      ST_TCONV:  n = CONV_CYC[c.res_code];
      ST_CCONV:  n = CONV_CYC[c.res_code];
      ST_TCALC:  n = TCALC_CYC;
      ST_CCALC:  n = CCALC_CYC;
      ST_PDOWN:  n = PD_CYC[c.rate_code];
      default:   n = 1;
    endcase
    return CNT_W'(n);
  endfunction

  // ==========================================================
  // state and decode
  // ==========================================================
  cms_state_t state;
  cms_state_t next_state;
  logic [2:0] cap_cnt;
  logic       expired;

  wire leave_boot  = (state == ST_BOOT);
  wire win_to_cmd  = (state == ST_WINDOW) && cmd_i.enter_calibration_command;
  wire cmd_resume  = (state == ST_CMD) && cmd_i.resume_normal_command;
  wire cycle_done  = (state == ST_CCALC) && expired;
  wire fast_rate   = (cfg_i.rate_code == 2'h0);
  // temperature slot every sixth capacitance cycle in update mode, every cycle in sleep mode
  wire temp_due    = cfg_i.sleep_mode || (cap_cnt == CMS_CAP_CNT_RST);
  wire phase_load  = (next_state != state);
  wire [CNT_W-1:0] next_len = phase_len(next_state, cfg_i);
  wire restart_cnt = (state == ST_WINDOW || state == ST_CMD)
                     && next_state == ST_WAKE;
  wire [2:0] cap_inc = cap_cnt + 3'h1;
  wire [2:0] next_cap_cnt =
      restart_cnt ? CMS_CAP_CNT_RST
    : (cycle_done && !cfg_i.sleep_mode)
      ? ((cap_cnt == CMS_TEMP_LAST) ? CMS_CAP_CNT_RST : cap_inc)
    : cap_cnt;

  always_comb
  begin
    next_state = state;
    case (state)
      ST_BOOT:   next_state = ST_WINDOW;
      // command inside window wins over expiry
      ST_WINDOW:
        if (cmd_i.enter_calibration_command)
          next_state = ST_CMD;
        else if (expired)
          next_state = ST_WAKE;
      ST_CMD:
        if (cmd_i.resume_normal_command)
          next_state = ST_WAKE;
      ST_WAKE:
        if (expired)
          next_state = temp_due ? ST_TCONV : ST_CCONV;
      ST_TCONV:
        if (expired)
          next_state = ST_TCALC;
      ST_TCALC:
        if (expired)
          next_state = ST_CCONV;
      ST_CCONV:
        if (expired)
          next_state = ST_CCALC;
      ST_CCALC:
        if (expired)
        begin
          if (cfg_i.sleep_mode)
            next_state = ST_SLEEP;
          else if (fast_rate)
            next_state = ST_WAKE;
          else
            next_state = ST_PDOWN;
        end
      ST_PDOWN:
        if (expired)
          next_state = ST_WAKE;
      ST_SLEEP:
        if (cmd_i.measure_request_cmd || !cfg_i.sleep_mode)
          next_state = ST_WAKE;
      default:   next_state = ST_BOOT;
    endcase
  end

  // ==========================================================
  // phase timer
  // ==========================================================
  // timer loaded with phase length
  cms_timer #(
    .CNT_W     (CNT_W)
  ) u_timer (
    .clk_sys_i (clk_sys_i),
    .reset_i   (reset_i),
    .load_i    (phase_load),
    .len_i     (next_len),
    .expired_o (expired)
  );

  // ==========================================================
  // registers
  // ==========================================================
  always_ff @(posedge clk_sys_i)
  begin
    if (reset_i)
      state <= ST_BOOT;
    else
      state <= next_state;
  end

  // counter restarts on leaving window or Command Mode
  always_ff @(posedge clk_sys_i)
  begin
    if (reset_i)
      cap_cnt <= CMS_CAP_CNT_RST;
    else
      cap_cnt <= next_cap_cnt;
  end

  cms_evt_t next_evt;
  assign next_evt.conv_start   = phase_load && (next_state == ST_TCONV
                                 || next_state == ST_CCONV);
  assign next_evt.conv_is_temp = (next_state == ST_TCONV);
  assign next_evt.dsp_start    = phase_load && (next_state == ST_TCALC
                                 || next_state == ST_CCALC);
  // result written as the cap calculation ends
  assign next_evt.result_write = cycle_done;

  wire next_i2c = (next_state == ST_BOOT || next_state == ST_WINDOW
                   || next_state == ST_CMD);
  wire next_pd  = (next_state == ST_PDOWN || next_state == ST_SLEEP);
  wire [3:0] next_bits = CMS_RES_BASE + {1'b0, cfg_i.res_code, 1'b0};

  always_ff @(posedge clk_sys_i)
  begin
    if (reset_i)
    begin
      evt_o          <= '0;
      conv_bits_o    <= CMS_RES_BASE;
      window_open_o  <= 1'b0;
      cmd_mode_o     <= 1'b0;
      powered_down_o <= 1'b0;
      i2c_forced_o   <= CMS_I2C_RST;
    end
    else
    begin
      evt_o          <= next_evt;
      conv_bits_o    <= next_bits;
      window_open_o  <= (next_state == ST_WINDOW);
      cmd_mode_o     <= (next_state == ST_CMD);
      powered_down_o <= next_pd;
      // forced I2C through window and Command Mode
      i2c_forced_o   <= next_i2c;
    end
  end

  assign phase_o = state;

  // ==========================================================
  // checks
  // ==========================================================
  logic [CNT_W-1:0] phase_cnt;
  always_ff @(posedge clk_sys_i)
  begin
    if (reset_i || phase_load)
      phase_cnt <= '0;
    else
      phase_cnt <= phase_cnt + 1'b1;
  end

  default clocking cb @(posedge clk_sys_i); endclocking
  default disable iff (reset_i);

  boot_start_a: assert property (
    state == ST_BOOT |=> state == ST_WINDOW && window_open_o)
    else $error("boot did not open the window");
  win_len_a: assert property (
    state == ST_WINDOW && next_state == ST_WAKE |->
    phase_cnt == CNT_W'((cfg_i.short_start ? WIN_SHORT_CYC
                         : WIN_LONG_CYC) - 1))
    else $error("command window length wrong");
  win_cmd_a: assert property (
    win_to_cmd |=> cmd_mode_o && state == ST_CMD)
    else $error("calibration command not taken");
  cmd_hold_a: assert property (
    state == ST_CMD && !cmd_i.resume_normal_command |=>
    state == ST_CMD && !evt_o.conv_start)
    else $error("measurement started in Command Mode");
  start_temp_a: assert property (
    restart_cnt |=> state == ST_WAKE ##0 temp_due)
    else $error("first cycle lacks temperature");
  conv_len_a: assert property (
    state == ST_CCONV && expired |->
    phase_cnt == CNT_W'(CONV_CYC[cfg_i.res_code] - 1))
    else $error("conversion length wrong");
  order_a: assert property (
    state == ST_TCALC && expired |=> state == ST_CCONV
    ##0 evt_o.conv_start && !evt_o.conv_is_temp)
    else $error("cap conversion must follow temp calc");
  result_a: assert property (
    cycle_done |=> evt_o.result_write ##1 !evt_o.result_write)
    else $error("result write pulse missing");
  fast_rate_a: assert property (
    evt_o.result_write && !cfg_i.sleep_mode && fast_rate |->
    state == ST_WAKE)
    else $error("fast rate inserted power-down");
  skip_temp_a: assert property (
    state == ST_WAKE && expired && !temp_due |=> state == ST_CCONV)
    else $error("temperature not skipped");
  sleep_hold_a: assert property (
    state == ST_SLEEP && cfg_i.sleep_mode
    && !cmd_i.measure_request_cmd |=> state == ST_SLEEP)
    else $error("sleep mode woke without request");
  i2c_win_a: assert property (
    window_open_o |-> i2c_forced_o)
    else $error("I2C not forced in window");

  cover property (win_to_cmd ##1 cmd_resume);
  cover property (state == ST_TCONV && !cfg_i.sleep_mode
                  && cap_cnt == CMS_CAP_CNT_RST);
  cover property (state == ST_SLEEP && cmd_i.measure_request_cmd);
  cover property (state == ST_PDOWN && expired);

endmodule

/* bench/cms_host_model.sv */
// host model: the microcontroller that sends commands to the sequencer
// assumes the bench calls its tasks; pulses launch at the falling edge
`timescale 1ns/10ps
module cms_host_model
  import cms_pkg::*;
(
  // clock
  input  wire logic         clk_sys_i,
  // commands towards the device
  output cms_pkg::cms_cmd_t cmd_o
);

  // ==========================================================
  // command pulses
  // ==========================================================
  initial cmd_o = '0;

  // one clean pulse; the sequencer samples it at a single rising edge
  // host command send
  task automatic send(input logic [2:0] which);
    @(negedge clk_sys_i);
    cmd_o = which;
    @(negedge clk_sys_i);
    cmd_o = '0;
  endtask

  // typical figures only; oscillator spread needs margin on waits
  // scaled worst wait
  function automatic int worst_wait(input int typ);
    return typ * 11 / 10 + 1;
  endfunction
endmodule

/* bench/cms_sequencer_tb.sv */
// testbench for the measurement sequencer with shortened phase counts
// assumes the host model drives commands; bench drives reset and config
`timescale 1ns/10ps
module cms_sequencer_tb;
  import cms_pkg::*;

  // ==========================================================
  // shortened timing
  // ==========================================================
  localparam int unsigned CONV [4] = '{6, 8, 10, 12};
  localparam int unsigned PD [4]   = '{1, 15, 25, 35};
  localparam logic [2:0]  ENTER    = 3'h4;
  localparam logic [2:0]  RESUME   = 3'h2;
  localparam logic [2:0]  MREQ     = 3'h1;

  logic       clk_sys_i;
  logic       reset_i;
  cms_cfg_t   cfg;
  cms_cmd_t   cmd;
  cms_evt_t   evt;
  logic [3:0] conv_bits;
  cms_state_t phase;
  logic       win_open;
  logic       cmd_mode;
  logic       pdown;
  logic       i2c_forced;
  int         err_total;
  int         checks_done;
  int         n;

  cms_sequencer #(
    .WIN_SHORT_CYC (20),
    .WIN_LONG_CYC  (40),
    .TCALC_CYC     (4),
    .CCALC_CYC     (5),
    .CONV_CYC      (CONV),
    .PD_CYC        (PD)
  ) u_cms_sequencer (
    .clk_sys_i      (clk_sys_i),
    .reset_i        (reset_i),
    .cfg_i          (cfg),
    .cmd_i          (cmd),
    .evt_o          (evt),
    .conv_bits_o    (conv_bits),
    .phase_o        (phase),
    .window_open_o  (win_open),
    .cmd_mode_o     (cmd_mode),
    .powered_down_o (pdown),
    .i2c_forced_o   (i2c_forced)
  );

  cms_host_model u_cms_host_model (
    .clk_sys_i (clk_sys_i),
    .cmd_o     (cmd)
  );

  // ==========================================================
  // shared tasks
  // ==========================================================
  task automatic check_val(input logic [31:0] seen, input logic [31:0] exp,
                           input string msg);
    checks_done++;
    if (seen !== exp)
    begin
      err_total++;
      $display("wrong value at %0t: %s seen %0h exp %0h", $time, msg,
               seen, exp);
    end
  endtask

  task automatic wait_phase(input cms_state_t st);
    int k;
    k = 0;
    while (phase !== st && k < u_cms_host_model.worst_wait(400))
    begin
      @(negedge clk_sys_i);
      k++;
    end
    check_val(phase, st, "phase not reached");
  endtask

  // counts falling edges spent in one phase, bounded
  task automatic measure(input cms_state_t st, output int len);
    len = 0;
    while (phase === st && len < 3000)
    begin
      @(negedge clk_sys_i);
      len++;
    end
  endtask

  task automatic do_reset(input cms_cfg_t c, input bit run_out);
    @(negedge clk_sys_i);
    reset_i = 1'b1;
    cfg = c;
    repeat (20) @(negedge clk_sys_i);
    check_val(phase, ST_BOOT, "reset phase");
    check_val({i2c_forced, conv_bits, evt}, 9'h180, "reset outputs");
    reset_i = 1'b0;
    @(negedge clk_sys_i);
    check_val({win_open, i2c_forced}, 2'h3, "window status");
    if (run_out)
    begin
      measure(ST_WINDOW, n);
      check_val(n, c.short_start ? 20 : 40, "window length");
    end
  endtask

  // one measurement cycle, phase by phase, with exact lengths
  task automatic check_cycle(input bit temp, input int r);
    wait_phase(ST_WAKE);
    measure(ST_WAKE, n);
    check_val(n, CMS_WAKE_CYC, "wakeup length");
    if (temp)
    begin
      check_val({phase, evt}, {ST_TCONV, 4'hC}, "temp conv");
      measure(ST_TCONV, n);
      check_val(n, CONV[r], "temp conv length");
      check_val({phase, evt}, {ST_TCALC, 4'h2}, "temp dsp");
      measure(ST_TCALC, n);
      check_val(n, 4, "temp dsp length");
    end
    check_val({phase, evt}, {ST_CCONV, 4'h8}, "cap conv");
    check_val(conv_bits, 4'h8 + 4'(2 * r), "conv bits");
    measure(ST_CCONV, n);
    check_val(n, CONV[r], "cap conv length");
    check_val({phase, evt}, {ST_CCALC, 4'h2}, "cap dsp");
    measure(ST_CCALC, n);
    check_val(n, 5, "cap dsp length");
    check_val(evt, 4'h1, "result write");
  endtask

  task automatic close_out;
    $display("checks %0d mismatches %0d", checks_done, err_total);
    if (err_total == 0 && checks_done > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask

  // ==========================================================
  // clock, watchdog and tests
  // ==========================================================
  initial
  begin
    clk_sys_i = 1'b0;
    forever #20 clk_sys_i = ~clk_sys_i;
  end

  // wakeup runs at full length: about 31000 cycles; wide margin
  initial
  begin
    repeat (50000) @(posedge clk_sys_i);
    err_total++;
    $display("watchdog expired at %0t", $time);
    close_out();
  end

  initial
  begin
    reset_i = 1'b1;
    cfg = '0;
    err_total = 0;
    checks_done = 0;
    // update mode, long window, every rate and resolution
    do_reset('{1'b0, 2'h0, 2'h0, 1'b0}, 1'b1);
    for (int i = 0; i < 8; i++)
    begin
      cfg.rate_code = 2'(i % 4);
      cfg.res_code = 2'(i % 4);
      check_cycle(i == 0 || i == 6, i % 4);
      if (i % 4 == 0)
        check_val(phase, ST_WAKE, "no power down");
      else
      begin
        check_val(pdown, 1'b1, "powered down");
        measure(ST_PDOWN, n);
        check_val(n, PD[i % 4], "power down length");
      end
    end
    $display("test update done, mismatches %0d", err_total);
    // command mode entry, hold and resume
    do_reset('{1'b0, 2'h0, 2'h1, 1'b1}, 1'b0);
    u_cms_host_model.send(MREQ);
    u_cms_host_model.send(ENTER);
    check_val({cmd_mode, win_open, i2c_forced}, 3'h5, "cmd mode");
    n = 0;
    repeat (60)
    begin
      @(negedge clk_sys_i);
      if (evt.conv_start !== 1'b0 || phase !== ST_CMD)
        n++;
    end
    u_cms_host_model.send(MREQ);
    check_val(n, 32'h0, "cmd mode hold");
    check_val(cmd_mode, 1'b1, "cmd mode level");
    u_cms_host_model.send(RESUME);
    check_cycle(1'b1, 1);
    check_cycle(1'b0, 1);
    $display("test command done, mismatches %0d", err_total);
    // sleep mode: one cycle after window, then only on request
    do_reset('{1'b1, 2'h2, 2'h2, 1'b1}, 1'b1);
    check_cycle(1'b1, 2);
    repeat (50) @(negedge clk_sys_i);
    check_val({phase, pdown}, {ST_SLEEP, 1'b1}, "sleep hold");
    u_cms_host_model.send(MREQ);
    check_cycle(1'b1, 2);
    check_val(phase, ST_SLEEP, "back to sleep");
    $display("test sleep done, mismatches %0d", err_total);
    close_out();
  end
endmodule
